// *** verilog/sic_pkg.sv ***
// Constants, tables and types for the stepper indexer and chopper block.
// Assumes a single 200 MHz system clock and pin inputs that arrive asynchronously.
// How it works
// [R1] Indexer advances one step of the selected resolution per step rising edge
// [R2] Direction input reverses the sequence walk order
// [R3] Resolution pins select full through 1/32 step
// [R4] Direct mode, hi select: gate low turns off
// [R5] Trip after blank holds decay until period end
// [R6] Trip comparison ignored during blank window
// [R7] Decay pin: low slow, high fast, float mixed
// [R8] Direct mode: polarity sets direction, reference sets level
// [R9] Controller supplies steady step rate, ramps speed
// [R10] Overtemperature disables outputs until it clears
// [R11] Resolution map and current table are tables
// [R12] Period and blank counted in clock cycles
package sic_pkg;

  localparam int CLK_NS = 5;
  localparam int PWM_PERIOD_NS = 50000;
  localparam int BLANK_NS = 1500;
  localparam int MIXED_FAST_NS = 12500;
  localparam int CNT_W = 16;
  localparam int MIX_W = 12;
  // Period is a longest time, blank a least time, mixed fast part a longest time
  localparam logic [CNT_W-1:0] PWM_PERIOD_CYC = CNT_W'(PWM_PERIOD_NS / CLK_NS);
  localparam logic [CNT_W-1:0] BLANK_CYC = CNT_W'((BLANK_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [MIX_W-1:0] MIXED_FAST_CYC = MIX_W'(MIXED_FAST_NS / CLK_NS);

  localparam int POS_W = 7;
  localparam logic [POS_W-1:0] HOME_POS = 7'h10;
  localparam logic [POS_W-1:0] QUARTER_TURN = 7'h20;
  localparam logic [5:0] QUAD_TOP = 6'h20;

  // Step increment per resolution code {hi, lo_float ? 2 : lo}
  localparam logic [POS_W-1:0] RES_STEP [0:7] = '{7'h20, 7'h10, 7'h08, 7'h08, 7'h04, 7'h02, 7'h01, 7'h01};

  // Quarter sine magnitudes, 33 points, full scale 255
  localparam logic [7:0] SINE_TBL [0:32] = '{
    8'h00, 8'h0d, 8'h19, 8'h25, 8'h32, 8'h3e, 8'h4a, 8'h56, 8'h62, 8'h6d, 8'h78, 8'h83,
    8'h8e, 8'h98, 8'ha2, 8'hab, 8'hb4, 8'hbd, 8'hc5, 8'hcd, 8'hd4, 8'hdb, 8'he1, 8'he7,
    8'hec, 8'hf0, 8'hf4, 8'hf7, 8'hfa, 8'hfc, 8'hfe, 8'hff, 8'hff};

  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_HOME_BIT = 1;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam int STAT_POS_LSB = 0;
  localparam int STAT_IDX_BIT = 8;
  localparam int STAT_OT_BIT = 9;
  localparam int STAT_SLEEP_BIT = 10;
  localparam int STAT_EN_BIT = 11;
  localparam int STAT_WST_LSB = 12;

  localparam int SYNC_W = 34;

  typedef enum logic [1:0] {ST_OFF, ST_DRIVE, ST_SLOW, ST_FAST} sic_state_e;
  typedef enum logic [1:0] {DK_SLOW, DK_FAST, DK_MIXED} sic_decay_e;

endpackage

// *** verilog/sic_sine_rom.sv ***
// Two-port quarter sine lookup with registered read data.
// Assumes addresses in 0 to 32; one cycle of read latency.
`timescale 1ns/1ps
`default_nettype none
module sic_sine_rom
  import sic_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic [5:0] i_addr_a,
  input wire logic [5:0] i_addr_b,
  output logic [7:0] o_data_a,
  output logic [7:0] o_data_b
);

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      o_data_a <= 8'h00;
      o_data_b <= 8'h00;
    end
    else if (i_ce)
    begin
      o_data_a <= SINE_TBL[i_addr_a]; // [R11]
      o_data_b <= SINE_TBL[i_addr_b]; // [R11]
    end
  end

endmodule
`default_nettype wire

// *** verilog/sic_chopper.sv ***
// Fixed period current chopper for one winding.
// Assumes trip and gate inputs already synchronised to i_clk_sys.
`timescale 1ns/1ps
`default_nettype none
module sic_chopper
  import sic_pkg::*;
#(
  parameter logic [CNT_W-1:0] PERIOD_CYC = PWM_PERIOD_CYC
)
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_enable,
  input wire logic i_gate,
  input wire logic i_off_when_low,
  input wire logic [1:0] i_decay_mode,
  input wire logic i_trip,
  output logic [1:0] o_state
);

  localparam logic [CNT_W-1:0] LAST_CYC = PERIOD_CYC - 16'h0001;

  sic_state_e state_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [MIX_W-1:0] fast_cnt_reg;
  logic period_end;
  logic chop_go;
  logic running;

  assign period_end = (cnt_reg == LAST_CYC);
  assign running = i_enable && i_gate && (state_reg != ST_OFF);
  assign chop_go = i_trip && (cnt_reg >= BLANK_CYC); // [R6]
  assign o_state = state_reg;

  // Counter held at zero while stopped so the first drive phase keeps its full blank
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      cnt_reg <= 16'h0000;
    else if (i_ce)
    begin
      if (!running || period_end)
        cnt_reg <= 16'h0000; // [R12]
      else
        cnt_reg <= cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      fast_cnt_reg <= 12'h000;
    else if (i_ce)
    begin
      if (state_reg == ST_FAST)
        fast_cnt_reg <= fast_cnt_reg + 12'h001;
      else
        fast_cnt_reg <= 12'h000;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      state_reg <= ST_OFF;
    else if (i_ce)
    begin
      if (!i_enable)
        state_reg <= ST_OFF;
      else if (!i_gate)
        state_reg <= i_off_when_low ? ST_OFF : ST_SLOW; // [R4]
      else
        case (state_reg)
          ST_OFF: state_reg <= ST_DRIVE;
          ST_DRIVE:
          begin
            if (!period_end && chop_go)
              state_reg <= (i_decay_mode == DK_SLOW) ? ST_SLOW : ST_FAST; // [R5] [R7]
          end
          ST_SLOW:
          begin
            if (period_end)
              state_reg <= ST_DRIVE; // [R5]
          end
          ST_FAST:
          begin
            if (period_end)
              state_reg <= ST_DRIVE; // [R5]
            else if (i_decay_mode == DK_MIXED && fast_cnt_reg >= MIXED_FAST_CYC - 12'h001)
              state_reg <= ST_SLOW; // [R7]
            else if (i_decay_mode == DK_SLOW)
              state_reg <= ST_SLOW; // [R7]
          end
          default: state_reg <= ST_OFF;
        endcase
    end
  end

  gate_off_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // [R4]
    (i_ce && i_enable && !i_gate && i_off_when_low) |=> (state_reg == ST_OFF))
    else $error("gate low did not turn winding off");

  blank_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // [R6]
    (i_ce && i_enable && i_gate && state_reg == ST_DRIVE && cnt_reg < BLANK_CYC) |=> (state_reg == ST_DRIVE))
    else $error("drive phase left during blank window");

  trip_chop_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // [R5]
    (i_ce && i_enable && i_gate && state_reg == ST_DRIVE && chop_go && !period_end)
      |=> (state_reg == ST_SLOW || state_reg == ST_FAST))
    else $error("trip after blank did not start decay");

  decay_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // [R5]
    (i_ce && i_enable && i_gate && (state_reg == ST_SLOW || state_reg == ST_FAST) && !period_end)
      |=> (state_reg != ST_DRIVE && state_reg != ST_OFF))
    else $error("decay ended before period end");

  decay_pick_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // [R7]
    (i_ce && i_enable && i_gate && state_reg == ST_DRIVE && chop_go && !period_end && i_decay_mode == DK_SLOW)
      |=> (state_reg == ST_SLOW))
    else $error("slow decay select not honoured");

endmodule
`default_nettype wire

// *** verilog/sic_top.sv ***
// Stepper indexer and chopper top: pin sync, indexer, current lookup, two choppers, registers.
// Assumes asynchronous pins, a register master on i_clk_sys, and chop comparators outside.
`timescale 1ns/1ps
`default_nettype none
module sic_top
  import sic_pkg::*;
#(
  parameter logic [CNT_W-1:0] PWM_PERIOD_CYC_P = PWM_PERIOD_CYC
)
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_indexer_mode,
  input wire logic i_advance_pulse,
  input wire logic i_rotation_direction,
  input wire logic i_resolution_select_lo,
  input wire logic i_resolution_select_lo_float,
  input wire logic i_resolution_select_hi,
  input wire logic [1:0] i_bridge_drive_gate,
  input wire logic [1:0] i_winding_polarity,
  input wire logic i_decay_select_winding_a,
  input wire logic i_decay_float_winding_a,
  input wire logic i_decay_select_winding_b,
  input wire logic i_decay_float_winding_b,
  input wire logic [1:0] i_chop_threshold,
  input wire logic [7:0] i_current_reference_a,
  input wire logic [7:0] i_current_reference_b,
  input wire logic i_overtemp,
  input wire logic i_low_power_request_n,
  output logic [3:0] o_winding_state,
  output logic [1:0] o_winding_dir,
  output logic [7:0] o_current_level_a,
  output logic [7:0] o_current_level_b,
  output logic o_fault
);

  function automatic logic [1:0] decay_mode(input logic level, input logic floating);
    if (floating)
      decay_mode = DK_MIXED;
    else if (level)
      decay_mode = DK_FAST;
    else
      decay_mode = DK_SLOW;
  endfunction

  // Fold a sequence position onto the quarter table, sign from the half turn
  function automatic logic [5:0] quad_addr(input logic [POS_W-1:0] pos);
    if (pos[5])
      quad_addr = QUAD_TOP - {1'b0, pos[4:0]};
    else
      quad_addr = {1'b0, pos[4:0]};
  endfunction

  // Two stage synchronisers for every pin; reference buses are quasi static
  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  logic adv_s;
  logic dir_s;
  logic lo_s;
  logic lofl_s;
  logic hi_s;
  logic indexer_s;
  logic [1:0] gate_s;
  logic [1:0] pol_s;
  logic [1:0] dk_lvl_s;
  logic [1:0] dk_fl_s;
  logic [1:0] trip_s;
  logic ot_s;
  logic awake_s;
  logic [7:0] ref_a_s;
  logic [7:0] ref_b_s;

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end
    else if (i_ce)
    begin
      sync1_reg <= {i_advance_pulse, i_rotation_direction, i_resolution_select_lo, i_resolution_select_lo_float,
                    i_resolution_select_hi, i_indexer_mode, i_bridge_drive_gate, i_winding_polarity,
                    i_decay_select_winding_b, i_decay_select_winding_a, i_decay_float_winding_b,
                    i_decay_float_winding_a, i_chop_threshold, i_overtemp, i_low_power_request_n,
                    i_current_reference_a, i_current_reference_b};
      sync2_reg <= sync1_reg;
    end
  end

  assign {adv_s, dir_s, lo_s, lofl_s, hi_s, indexer_s, gate_s, pol_s, dk_lvl_s, dk_fl_s, trip_s, ot_s, awake_s,
          ref_a_s, ref_b_s} = sync2_reg;

  // Register file
  logic ctrl_en_reg;
  logic home_req;
  logic enable;
  logic [1:0] st_a;
  logic [1:0] st_b;
  logic [POS_W-1:0] pos_reg;

  assign home_req = !awake_s || (i_wr && i_addr == CTRL_OFS && i_wdata[CTRL_HOME_BIT]);
  assign enable = ctrl_en_reg && !ot_s && awake_s; // [R10]

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      ctrl_en_reg <= CTRL_EN_RST;
    else if (i_ce && i_wr && i_addr == CTRL_OFS)
      ctrl_en_reg <= i_wdata[CTRL_EN_BIT];
  end

  // Read data valid only in the cycle after the strobe; unmapped offsets read zero
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      o_rdata <= 32'h0000_0000;
    else if (i_ce)
    begin
      o_rdata <= 32'h0000_0000;
      if (i_rd)
        case (i_addr)
          CTRL_OFS: o_rdata[CTRL_EN_BIT] <= ctrl_en_reg;
          STATUS_OFS:
          begin
            o_rdata[STAT_POS_LSB +: POS_W] <= pos_reg;
            o_rdata[STAT_IDX_BIT] <= indexer_s;
            o_rdata[STAT_OT_BIT] <= ot_s;
            o_rdata[STAT_SLEEP_BIT] <= !awake_s;
            o_rdata[STAT_EN_BIT] <= ctrl_en_reg;
            o_rdata[STAT_WST_LSB +: 4] <= {st_b, st_a};
          end
          default: o_rdata <= 32'h0000_0000;
        endcase
    end
  end

  // Indexer
  logic adv_d_reg;
  logic step_ok;
  logic [POS_W-1:0] step_sz;

  assign step_ok = indexer_s && adv_s && !adv_d_reg; // [R1]
  assign step_sz = RES_STEP[{hi_s, lofl_s ? 2'h2 : {1'b0, lo_s}}]; // [R3] [R11]

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      adv_d_reg <= 1'b0;
    else if (i_ce)
      adv_d_reg <= adv_s;
  end

  // Seven bit position wraps naturally over one electrical turn
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      pos_reg <= HOME_POS;
    else if (i_ce)
    begin
      if (home_req)
        pos_reg <= HOME_POS;
      else if (step_ok)
        pos_reg <= dir_s ? pos_reg + step_sz : pos_reg - step_sz; // [R1] [R2] [R11]
    end
  end

  // Winding A follows sine, winding B cosine of the position
  logic [POS_W-1:0] pos_cos;
  logic [7:0] rom_a;
  logic [7:0] rom_b;
  logic neg_a_reg;
  logic neg_b_reg;

  assign pos_cos = pos_reg + QUARTER_TURN;

  sic_sine_rom u_rom (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_addr_a(quad_addr(pos_reg)),
    .i_addr_b(quad_addr(pos_cos)),
    .o_data_a(rom_a),
    .o_data_b(rom_b)
  );

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      neg_a_reg <= 1'b0;
      neg_b_reg <= 1'b0;
    end
    else if (i_ce)
    begin
      neg_a_reg <= pos_reg[POS_W-1];
      neg_b_reg <= pos_cos[POS_W-1];
    end
  end

  // Indexer drives both bridges; direct mode takes gate, polarity and reference per winding
  logic gate_a;
  logic gate_b;
  logic off_low;

  assign gate_a = indexer_s || gate_s[0];
  assign gate_b = indexer_s || gate_s[1];
  assign off_low = !indexer_s && hi_s; // [R4]

  sic_chopper #(.PERIOD_CYC(PWM_PERIOD_CYC_P)) u_chop_a (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_enable(enable),
    .i_gate(gate_a),
    .i_off_when_low(off_low),
    .i_decay_mode(decay_mode(dk_lvl_s[0], dk_fl_s[0])),
    .i_trip(trip_s[0]),
    .o_state(st_a)
  );

  sic_chopper #(.PERIOD_CYC(PWM_PERIOD_CYC_P)) u_chop_b (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_enable(enable),
    .i_gate(gate_b),
    .i_off_when_low(off_low),
    .i_decay_mode(decay_mode(dk_lvl_s[1], dk_fl_s[1])),
    .i_trip(trip_s[1]),
    .o_state(st_b)
  );

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      o_winding_state <= 4'h0;
      o_winding_dir <= 2'h0;
      o_current_level_a <= 8'h00;
      o_current_level_b <= 8'h00;
      o_fault <= 1'b0;
    end
    else if (i_ce)
    begin
      o_winding_state <= {st_b, st_a}; // [R10]
      o_winding_dir <= indexer_s ? {!neg_b_reg, !neg_a_reg} : pol_s; // [R8]
      o_current_level_a <= indexer_s ? rom_a : ref_a_s; // [R8]
      o_current_level_b <= indexer_s ? rom_b : ref_b_s; // [R8]
      o_fault <= ot_s; // [R10]
    end
  end

  step_edge_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // [R1]
    (i_ce && !step_ok && !home_req) |=> (pos_reg == $past(pos_reg)))
    else $error("position moved without a step edge");

  step_dir_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // [R2]
    (i_ce && step_ok && !home_req)
      |=> (pos_reg == ($past(dir_s) ? POS_W'($past(pos_reg) + $past(step_sz))
                                    : POS_W'($past(pos_reg) - $past(step_sz)))))
    else $error("step went the wrong way or size");

  res_fine_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // [R3]
    (hi_s && lofl_s) |-> (step_sz == 7'h01))
    else $error("finest resolution is not one position");

  heat_off_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // [R10]
    (ot_s && i_ce) ##1 (ot_s && i_ce) |=> (o_winding_state == 4'h0 && o_fault))
    else $error("outputs not disabled on overtemperature");

  pol_follow_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // [R8]
    (i_ce && !indexer_s) |=> (o_winding_dir == $past(pol_s) && o_current_level_a == $past(ref_a_s)))
    else $error("direct mode direction or level not followed");

endmodule
`default_nettype wire

// *** verif/sic_ctrl_model.sv ***
// Controller model: drives the step pin as a burst of square wave periods.
// Assumes the bench sets direction and resolution pins before each burst.
`timescale 1ns/1ps
`default_nettype none
module sic_ctrl_model
#(
  parameter int HALF = 4
)
(
  input wire logic i_clk_sys,
  input wire logic i_start,
  input wire logic [7:0] i_count,
  output logic o_advance_pulse,
  output logic o_busy
);
  int cnt_reg = 0;
  int left_reg = 0;
  logic pulse_reg = 1'b0;
  logic busy_reg = 1'b0;
  assign o_advance_pulse = pulse_reg;
  assign o_busy = busy_reg;
  // Steady rate; halves of HALF cycles keep pulses wider than the sync needs
  always @(posedge i_clk_sys)
  begin
    if (i_start)
    begin
      left_reg <= 2 * int'(i_count);
      cnt_reg <= 0;
      busy_reg <= (i_count != 8'h00);
    end
    else if (busy_reg)
    begin
      if (cnt_reg == HALF - 1)
      begin
        cnt_reg <= 0;
        pulse_reg <= ~pulse_reg;
        left_reg <= left_reg - 1;
        if (left_reg == 1)
          busy_reg <= 1'b0;
      end
      else
        cnt_reg <= cnt_reg + 1;
    end
  end
endmodule
`default_nettype wire

// *** verif/tb_sic_top.sv ***
// Bench for the stepper indexer and chopper top: step pins, register port, choppers.
// Assumes a 400 cycle PWM period so whole periods fit in a short run.
`timescale 1ns/1ps
`default_nettype none
module tb_sic_top;
  import sic_pkg::*;
  localparam logic [CNT_W-1:0] PER = 16'h0190;
  logic clk;
  logic rst_n;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic ind;
  logic step;
  logic dir;
  logic lo;
  logic lof;
  logic hi;
  logic [1:0] gate;
  logic [1:0] pol;
  logic da;
  logic fa;
  logic [1:0] trip;
  logic [7:0] ref_a;
  logic [7:0] ref_b;
  logic ot;
  logic slp_n;
  logic [3:0] wst;
  logic [1:0] wdir;
  logic [7:0] lvl_a;
  logic [7:0] lvl_b;
  logic fault;
  logic go;
  logic [7:0] n_steps;
  logic busy;
  logic ce;
  int errors;
  int tests_run;

  sic_top #(.PWM_PERIOD_CYC_P(PER)) u_dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_ce(ce),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_indexer_mode(ind), .i_advance_pulse(step), .i_rotation_direction(dir),
    .i_resolution_select_lo(lo), .i_resolution_select_lo_float(lof), .i_resolution_select_hi(hi),
    .i_bridge_drive_gate(gate), .i_winding_polarity(pol), .i_decay_select_winding_a(da),
    .i_decay_float_winding_a(fa), .i_decay_select_winding_b(da), .i_decay_float_winding_b(fa),
    .i_chop_threshold(trip), .i_current_reference_a(ref_a), .i_current_reference_b(ref_b),
    .i_overtemp(ot), .i_low_power_request_n(slp_n), .o_winding_state(wst), .o_winding_dir(wdir),
    .o_current_level_a(lvl_a), .o_current_level_b(lvl_b), .o_fault(fault));

  sic_ctrl_model #(.HALF(4)) u_ctrl (.i_clk_sys(clk), .i_start(go), .i_count(n_steps),
    .o_advance_pulse(step), .o_busy(busy));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic report_and_stop;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic pos_is(input logic [6:0] e);
    logic [31:0] d;
    reg_rd(STATUS_OFS, d);
    chk("position", 32'(e), 32'(d[6:0]));
  endtask

  task automatic steps(input logic [7:0] n);
    int k;
    @(posedge clk);
    n_steps <= n;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    #1;
    for (k = 0; k < 4000 && busy === 1'b1; k++)
      cyc(1);
    if (busy !== 1'b0)
    begin
      errors++;
      report_and_stop();
    end
    cyc(8);
  endtask

  task automatic t_reset;
    logic [31:0] d;
    reg_rd(CTRL_OFS, d);
    chk("ctrl after reset", 32'h0000_0001, d);
    reg_rd(STATUS_OFS, d);
    chk("status after reset", 32'h0000_0910, 32'(d[11:0]));
    reg_rd(8'h08, d);
    chk("unmapped read", 32'h0000_0000, d);
    chk("level a at home", 32'h0000_00b4, 32'(lvl_a));
    chk("level b at home", 32'h0000_00b4, 32'(lvl_b));
  endtask

  // Both windings see the same trip and decay pins, so both are judged alike
  task automatic t_chop(input logic s, input logic f, input logic t, input logic [1:0] dk);
    int nd;
    int bad;
    logic [1:0] st;
    nd = 0;
    bad = 0;
    @(posedge clk);
    da <= s;
    fa <= f;
    trip <= {t, t};
    cyc(800);
    for (int i = 0; i < 400; i++)
    begin
      cyc(1);
      for (int w = 0; w < 2; w++)
      begin
        st = wst[2*w +: 2];
        if (st === 2'b01)
          nd++;
        else if (st !== dk)
          bad++;
      end
    end
    chk("decay state misses", 32'h0000_0000, 32'(bad));
    tests_run++;
    if (t ? (nd < 600 || nd > 606) : nd != 800)
    begin
      errors++;
      $display("MISMATCH drive cycles expected %0d seen %0d", t ? 602 : 800, nd);
    end
  endtask

  task automatic t_step;
    logic [6:0] e;
    for (int k = 0; k < 6; k++)
    begin
      reg_wr(CTRL_OFS, 32'h0000_0003);
      @(posedge clk);
      hi <= (k >= 3);
      lo <= (k % 3 == 1);
      lof <= (k % 3 == 2);
      dir <= 1'b1;
      cyc(4);
      e = 7'h10 + 7'(3 * (32 >> k));
      steps(8'h03);
      pos_is(e);
      if (k == 0)
        chk("indexer dir", 32'h0000_0002, 32'(wdir));
      if (k == 1)
        chk("level a at half turn", 32'h0000_0000, 32'(lvl_a));
      if (k == 1)
        chk("level b at half turn", 32'h0000_00ff, 32'(lvl_b));
      @(posedge clk);
      dir <= 1'b0;
      cyc(4);
      steps(8'h05);
      e = e - 7'(5 * (32 >> k));
      pos_is(e);
    end
    @(posedge clk);
    ind <= 1'b0;
    cyc(4);
    steps(8'h02);
    pos_is(e);
  endtask

  task automatic t_direct;
    @(posedge clk);
    gate <= 2'b00;
    hi <= 1'b1;
    cyc(10);
    chk("gate low off", 32'h0000_0000, 32'(wst));
    @(posedge clk);
    hi <= 1'b0;
    cyc(10);
    chk("gate low brake", 32'h0000_000a, 32'(wst));
    // Brake decay runs out its period before the next drive phase
    @(posedge clk);
    gate <= 2'b11;
    pol <= 2'b01;
    ref_a <= 8'h5a;
    ref_b <= 8'hc3;
    cyc(410);
    chk("direct drive", 32'h0000_0005, 32'(wst));
    chk("direction", 32'h0000_0001, 32'(wdir));
    chk("level a", 32'h0000_005a, 32'(lvl_a));
    chk("level b", 32'h0000_00c3, 32'(lvl_b));
    @(posedge clk);
    pol <= 2'b10;
    cyc(10);
    chk("direction", 32'h0000_0002, 32'(wdir));
  endtask

  task automatic t_prot;
    logic [31:0] d;
    @(posedge clk);
    ind <= 1'b1;
    ot <= 1'b1;
    cyc(30);
    chk("overtemp states", 32'h0000_0000, 32'(wst));
    chk("fault", 32'h0000_0001, 32'(fault));
    reg_rd(STATUS_OFS, d);
    chk("overtemp flag", 32'h0000_0001, 32'(d[STAT_OT_BIT]));
    @(posedge clk);
    ot <= 1'b0;
    cyc(10);
    chk("fault cleared", 32'h0000_0000, 32'(fault));
    chk("states back", 32'h0000_0005, 32'(wst));
    reg_wr(CTRL_OFS, 32'h0000_0000);
    cyc(6);
    chk("disabled states", 32'h0000_0000, 32'(wst));
    reg_wr(CTRL_OFS, 32'h0000_0001);
    @(posedge clk);
    slp_n <= 1'b0;
    cyc(10);
    chk("sleep states", 32'h0000_0000, 32'(wst));
    reg_rd(STATUS_OFS, d);
    chk("sleep flag", 32'h0000_0001, 32'(d[STAT_SLEEP_BIT]));
    chk("sleep home", 32'h0000_0010, 32'(d[6:0]));
    @(posedge clk);
    slp_n <= 1'b1;
  endtask

  // Pulses while the clock enable is low must leave no trace
  task automatic t_freeze;
    cyc(10);
    @(posedge clk);
    ce <= 1'b0;
    steps(8'h02);
    @(posedge clk);
    ce <= 1'b1;
    cyc(4);
    pos_is(7'h10);
  endtask

  initial
  begin
    errors = 0;
    tests_run = 0;
    rst_n = 1'b0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    wr = 1'b0;
    rd = 1'b0;
    ind = 1'b1;
    dir = 1'b1;
    lo = 1'b0;
    lof = 1'b0;
    hi = 1'b0;
    gate = 2'b11;
    pol = 2'b00;
    da = 1'b0;
    fa = 1'b0;
    trip = 2'b00;
    ref_a = 8'h00;
    ref_b = 8'h00;
    ot = 1'b0;
    slp_n = 1'b1;
    go = 1'b0;
    n_steps = 8'h00;
    ce = 1'b1;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    cyc(10);
    t_reset();
    t_chop(1'b0, 1'b0, 1'b1, 2'b10);
    t_chop(1'b1, 1'b0, 1'b1, 2'b11);
    t_chop(1'b0, 1'b1, 1'b1, 2'b11);
    t_chop(1'b0, 1'b0, 1'b0, 2'b10);
    t_step();
    t_direct();
    t_prot();
    t_freeze();
    report_and_stop();
  end
endmodule
`default_nettype wire
